// [rtl/config_map.vh]
// Constants of the configuration index/data port logic: port
// addresses, key values, global indexes, field positions, bank numbers.
// Assumes inclusion by the configuration access module, its checker and its bench.
`ifndef CONFIG_MAP_VH
`define CONFIG_MAP_VH

// -----------------------------------------------------------------
// Port pair and keys
// -----------------------------------------------------------------
`define PORT_BASE_LOW 16'h002e
`define PORT_BASE_HIGH 16'h004e
`define KEY_UNLOCK 8'h87
`define KEY_LOCK 8'haa

// -----------------------------------------------------------------
// Global register space
// -----------------------------------------------------------------
`define GLOBAL_LAST 8'h2f
`define BANK_FIRST 8'h30
`define GLOBAL_DEPTH 48
`define IDX_BANK_SELECT 8'h07
`define IDX_STRAP_READBACK 8'h26
`define IDX_MAIN_STRAPS 8'h2a
`define IDX_STANDBY_STRAPS 8'h2b
`define BIT_PORT_STRAP 6
`define BIT_CLOCK_STRAP 0
`define BIT_PIN_STRAP 1
`define BIT_STANDBY_STRAP 0
`define RESET_INDEX 8'h00
`define RESET_BANK 8'h00
`define READ_IDLE 8'hff

// -----------------------------------------------------------------
// Clock rates
// -----------------------------------------------------------------
`define CLOCK_MHZ_HIGH 6'h30
`define CLOCK_MHZ_LOW 6'h18

// -----------------------------------------------------------------
// Function banks and their target codes
// -----------------------------------------------------------------
`define BANK_SERIAL_A 8'h02
`define BANK_SERIAL_B 8'h03
`define BANK_GPIO_A 8'h07
`define BANK_GPIO_WDT 8'h08
`define BANK_GPIO_B 8'h0f
`define BANK_SERIAL_C 8'h10
`define BANK_SERIAL_D 8'h11
`define BANK_POST 8'h14
`define TGT_NONE 3'h0
`define TGT_SERIAL_A 3'h1
`define TGT_SERIAL_B 3'h2
`define TGT_SERIAL_C 3'h3
`define TGT_SERIAL_D 3'h4
`define TGT_GPIO 3'h5
`define TGT_GPIO_WDT 3'h6
`define TGT_POST 3'h7

`endif

// [rtl/config_index_port_access.v]
// Configuration index/data port pair with unlock key, global registers,
// banked function register access and strap latching.
// Assumes one-cycle I/O read/write strobes synchronous to clk_sys and
// function banks that answer reads within the strobe cycle.
// Assumes strap pins hold steady while their own reset is held;
// sys_rst doubles as the standby resume reset.
//
// Operation
// - Port pair 4E/4F if strap high, else 2E/2F
// - Port strap latched, relatched from the pin by bus reset
// - Clock taken as 48 or 24 MHz
// - Clock, pin straps follow main power good
// - Standby strap restored only by standby reset
// - Index at lower port selects register, data accesses it
// - Data updates only in extended mode
// - Two 87h writes enter extended mode
// - Writing AAh leaves extended mode
// - Indexes 00h-2Fh reach global registers
// - Index 07h selects bank for 30h upward
// - Bank numbers map to functions, others reserved
// - Index at unlock address, data one above
// - Global 26h bit 6 shows port strap
`timescale 1ns/1ns
`default_nettype none
`include "config_map.vh"

module config_index_port_access #(
  parameter ADDR_W = 16
) (
  // Clock and resets
  input wire clk_sys,
  input wire sys_rst,
  input wire bus_reset,
  input wire main_power_good,
  // Strap pins
  input wire port_address_strap,
  input wire clock_rate_strap,
  input wire pin_function_strap,
  input wire standby_strap,
  // Host I/O cycles
  input wire io_wr,
  input wire io_rd,
  input wire [ADDR_W-1:0] io_addr,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  output reg io_rvalid,
  // Function bank access
  output reg bank_wr,
  output reg bank_rd,
  output reg [2:0] bank_target,
  output reg [7:0] bank_index,
  output reg [7:0] bank_wdata,
  input wire [7:0] bank_rdata,
  // Configuration state
  output reg extended_mode,
  output reg [7:0] function_bank_select,
  output reg port_address_sel,
  output reg [5:0] main_clock_mhz,
  output reg pin_function_sel,
  output reg standby_strap_sel
);

  // -----------------------------------------------------------------
  // Bank number decode
  // -----------------------------------------------------------------
  function [2:0] bank_decode;
    input [7:0] num;
    begin
      case (num)
        `BANK_SERIAL_A: bank_decode = `TGT_SERIAL_A;
        `BANK_SERIAL_B: bank_decode = `TGT_SERIAL_B;
        `BANK_SERIAL_C: bank_decode = `TGT_SERIAL_C;
        `BANK_SERIAL_D: bank_decode = `TGT_SERIAL_D;
        `BANK_GPIO_A: bank_decode = `TGT_GPIO;
        `BANK_GPIO_B: bank_decode = `TGT_GPIO;
        `BANK_GPIO_WDT: bank_decode = `TGT_GPIO_WDT;
        `BANK_POST: bank_decode = `TGT_POST;
        default: bank_decode = `TGT_NONE;
      endcase
    end
  endfunction

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  // Key states: locked, one key seen, extended mode
  localparam [1:0] ST_LOCKED = 2'h0;
  localparam [1:0] ST_HALF = 2'h1;
  localparam [1:0] ST_OPEN = 2'h2;
  reg [1:0] key_state;
  reg [1:0] next_key_state;
  reg [7:0] next_config_index;
  reg [7:0] config_index;
  reg port_strap_result;
  reg clock_strap_result;
  reg pin_strap_result;
  reg standby_strap_result;
  reg [7:0] global_regs [0:`GLOBAL_DEPTH-1];
  integer i;

  // Port, clock/pin and standby straps each have a reset of their own
  wire config_reset = sys_rst | bus_reset;
  wire main_reset = sys_rst | ~main_power_good;
  wire standby_reset = sys_rst;

  // -----------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------
  wire [ADDR_W-1:0] base_addr;
  wire [ADDR_W-1:0] data_addr;
  wire hit_index;
  wire hit_data;
  wire is_global;
  wire [2:0] cur_target;

  assign base_addr = port_strap_result ? `PORT_BASE_HIGH : `PORT_BASE_LOW;
  assign data_addr = base_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
  assign hit_index = (io_addr == base_addr);
  assign hit_data = (io_addr == data_addr);
  assign is_global = (config_index <= `GLOBAL_LAST);
  assign cur_target = bank_decode(function_bank_select);

  wire wr_index = io_wr & hit_index;
  wire wr_data = io_wr & hit_data & extended_mode;
  wire rd_data = io_rd & hit_data & extended_mode;
  wire wr_global = wr_data & is_global;
  wire bank_hit = ~is_global & (cur_target != `TGT_NONE);
  wire bank_access = (wr_data | rd_data) & bank_hit;

  // -----------------------------------------------------------------
  // Key and global write decode
  // -----------------------------------------------------------------
  wire key_unlock = wr_index & (io_wdata == `KEY_UNLOCK);
  wire key_lock = wr_index & (io_wdata == `KEY_LOCK);
  wire wr_bank_select = wr_global & (config_index == `IDX_BANK_SELECT);
  wire wr_port_strap = wr_global & (config_index == `IDX_STRAP_READBACK);
  wire wr_main_straps = wr_global & (config_index == `IDX_MAIN_STRAPS);
  wire wr_standby_strap = wr_global & (config_index == `IDX_STANDBY_STRAPS);

  // -----------------------------------------------------------------
  // Global register read mux
  // -----------------------------------------------------------------
  reg [7:0] global_rd;

  always @* begin
    global_rd = global_regs[config_index[5:0]];
    case (config_index)
      `IDX_BANK_SELECT: begin
        global_rd = function_bank_select;
      end
      `IDX_STRAP_READBACK: begin
        global_rd[`BIT_PORT_STRAP] = port_strap_result;
      end
      `IDX_MAIN_STRAPS: begin
        global_rd = 8'h00;
        global_rd[`BIT_CLOCK_STRAP] = clock_strap_result;
        global_rd[`BIT_PIN_STRAP] = pin_strap_result;
      end
      `IDX_STANDBY_STRAPS: begin
        global_rd = 8'h00;
        global_rd[`BIT_STANDBY_STRAP] = standby_strap_result;
      end
      default: begin
        if (is_global) begin
          global_rd = global_regs[config_index[5:0]];
        end else begin
          global_rd = `READ_IDLE;
        end
      end
    endcase
  end

  // -----------------------------------------------------------------
  // Unlock key state machine and index port
  // -----------------------------------------------------------------
  // A half unlock is dropped by any other index-port value
  always @* begin
    next_key_state = key_state;
    next_config_index = config_index;
    case (key_state)
      ST_LOCKED: begin
        if (key_unlock) begin
          next_key_state = ST_HALF;
        end
      end
      ST_HALF: begin
        if (key_unlock) begin
          next_key_state = ST_OPEN;
        end else if (wr_index) begin
          next_key_state = ST_LOCKED;
        end
      end
      ST_OPEN: begin
        if (key_lock) begin
          next_key_state = ST_LOCKED;
        end else if (wr_index) begin
          next_config_index = io_wdata;
        end
      end
      default: begin
        next_key_state = ST_LOCKED;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (config_reset) begin
      key_state <= ST_LOCKED;
      extended_mode <= 1'b0;
      config_index <= `RESET_INDEX;
    end else begin
      key_state <= next_key_state;
      extended_mode <= (next_key_state == ST_OPEN);
      config_index <= next_config_index;
    end
  end

  // -----------------------------------------------------------------
  // Global registers and bank select
  // -----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (config_reset) begin
      function_bank_select <= `RESET_BANK;
      for (i = 0; i < `GLOBAL_DEPTH; i = i + 1) begin
        global_regs[i] <= 8'h00;
      end
    end else if (wr_global) begin
      if (wr_bank_select) begin
        function_bank_select <= io_wdata;
      end
      global_regs[config_index[5:0]] <= io_wdata;
    end
  end

  // -----------------------------------------------------------------
  // Strap results, under port, main and standby resets
  // -----------------------------------------------------------------
  // Port strap follows the pin while the bus reset is held
  always @(posedge clk_sys) begin
    if (config_reset) begin
      port_strap_result <= port_address_strap;
    end else if (wr_port_strap) begin
      port_strap_result <= io_wdata[`BIT_PORT_STRAP];
    end
  end

  // Clock and pin straps follow the pins while main power is not good
  always @(posedge clk_sys) begin
    if (main_reset) begin
      clock_strap_result <= clock_rate_strap;
      pin_strap_result <= pin_function_strap;
    end else if (wr_main_straps) begin
      clock_strap_result <= io_wdata[`BIT_CLOCK_STRAP];
      pin_strap_result <= io_wdata[`BIT_PIN_STRAP];
    end
  end

  // Standby strap is untouched by bus reset and main power good
  always @(posedge clk_sys) begin
    if (standby_reset) begin
      standby_strap_result <= standby_strap;
    end else if (wr_standby_strap) begin
      standby_strap_result <= io_wdata[`BIT_STANDBY_STRAP];
    end
  end

  // -----------------------------------------------------------------
  // Function bank access
  // -----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (config_reset) begin
      bank_wr <= 1'b0;
      bank_rd <= 1'b0;
      bank_target <= `TGT_NONE;
      bank_index <= 8'h00;
      bank_wdata <= 8'h00;
    end else begin
      bank_wr <= 1'b0;
      bank_rd <= 1'b0;
      if (bank_access) begin
        bank_wr <= wr_data;
        bank_rd <= rd_data;
        bank_target <= cur_target;
        bank_index <= config_index;
        bank_wdata <= io_wdata;
      end
    end
  end

  // -----------------------------------------------------------------
  // Read answers
  // -----------------------------------------------------------------
  // Reserved banks and locked data reads return the idle value
  reg [7:0] next_io_rdata;

  always @* begin
    if (io_rd && hit_index) begin
      next_io_rdata = extended_mode ? config_index : `READ_IDLE;
    end else if (rd_data && is_global) begin
      next_io_rdata = global_rd;
    end else if (rd_data && bank_hit) begin
      next_io_rdata = bank_rdata;
    end else begin
      next_io_rdata = `READ_IDLE;
    end
  end

  always @(posedge clk_sys) begin
    if (config_reset) begin
      io_rdata <= `READ_IDLE;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= io_rd & (hit_index | hit_data);
      io_rdata <= next_io_rdata;
    end
  end

  // -----------------------------------------------------------------
  // Strap outputs
  // -----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      port_address_sel <= 1'b0;
      main_clock_mhz <= `CLOCK_MHZ_LOW;
      pin_function_sel <= 1'b0;
      standby_strap_sel <= 1'b0;
    end else begin
      port_address_sel <= port_strap_result;
      main_clock_mhz <= clock_strap_result ? `CLOCK_MHZ_HIGH : `CLOCK_MHZ_LOW;
      pin_function_sel <= pin_strap_result;
      standby_strap_sel <= standby_strap_result;
    end
  end

endmodule

`default_nettype wire

// [dv/config_index_port_access_chk.sv]
// Checker of the configuration index/data port logic.
// Assumes binding to config_index_port_access and config_map.vh on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "config_map.vh"
module config_index_port_access_chk #(
  parameter ADDR_W = 16
) (
  // Clock, resets and clock rate strap
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic bus_reset,
  input wire logic main_power_good,
  input wire logic clock_rate_strap,
  // Host cycles
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [ADDR_W-1:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid,
  // Bank and state
  input wire logic bank_wr,
  input wire logic [2:0] bank_target,
  input wire logic extended_mode,
  input wire logic [7:0] function_bank_select,
  input wire logic port_address_sel,
  input wire logic [5:0] main_clock_mhz
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst || bus_reset);
  wire [ADDR_W-1:0] base = port_address_sel ? `PORT_BASE_HIGH : `PORT_BASE_LOW;
  wire hit_i = io_addr == base;
  wire hit_d = io_addr == base + 1'b1;
  wire key_on = io_wr && hit_i && io_wdata == `KEY_UNLOCK;
  wire key_off = io_wr && hit_i && io_wdata == `KEY_LOCK;
  sequence s_unlock;
    key_on ##1 key_on;
  endsequence
  a_unlock_enter: assert property (s_unlock |=> extended_mode)
    else $error("unlock pair did not enter extended mode");
  a_enter_cause: assert property ($rose(extended_mode) |-> $past(key_on))
    else $error("extended mode entered without key");
  a_lock_exit: assert property (extended_mode && key_off |=> !extended_mode)
    else $error("lock key did not leave extended mode");
  a_read_answer: assert property (io_rd && (hit_i || hit_d) |=> io_rvalid)
    else $error("port read not answered");
  a_answer_cause: assert property (io_rvalid |-> $past(io_rd && (hit_i || hit_d)))
    else $error("read answer without port read");
  a_idle_data: assert property (!io_rvalid |-> io_rdata == `READ_IDLE)
    else $error("read data not idle outside answer");
  a_locked_read: assert property (!extended_mode && io_rd && hit_d |=> io_rdata == `READ_IDLE)
    else $error("locked data read not idle");
  a_locked_write: assert property (!extended_mode && io_wr && hit_d
    |=> !bank_wr && $stable(function_bank_select))
    else $error("locked data write took effect");
  a_bank_cause: assert property (bank_wr |-> $past(extended_mode && io_wr && hit_d)
    && bank_target != `TGT_NONE)
    else $error("bank strobe without unlocked data write");
  a_clock_rate: assert property ((!main_power_good && $stable(clock_rate_strap))[*3]
    |-> main_clock_mhz == (clock_rate_strap ? `CLOCK_MHZ_HIGH : `CLOCK_MHZ_LOW))
    else $error("clock rate does not follow strap");
endmodule
bind config_index_port_access config_index_port_access_chk #(.ADDR_W(ADDR_W)) u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .bus_reset(bus_reset),
  .main_power_good(main_power_good), .clock_rate_strap(clock_rate_strap),
  .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
  .io_rdata(io_rdata), .io_rvalid(io_rvalid), .bank_wr(bank_wr),
  .bank_target(bank_target), .extended_mode(extended_mode),
  .function_bank_select(function_bank_select), .port_address_sel(port_address_sel),
  .main_clock_mhz(main_clock_mhz));
`default_nettype wire

// [dv/bank_model.sv]
// Function bank model: answers reads with the last value written.
// Assumes the bank strobes of config_index_port_access.
`timescale 1ns/1ns
`default_nettype none
module bank_model (
  // Clock
  input wire logic clk_sys,
  // Bank side
  input wire logic bank_wr,
  input wire logic [7:0] bank_wdata,
  output logic [7:0] bank_rdata
);
  always @(posedge clk_sys) begin
    if (bank_wr) begin
      bank_rdata <= bank_wdata;
    end
  end
endmodule
`default_nettype wire

// [dv/test_config_index_port_access.sv]
// Bench of the configuration index/data port logic with a bank model.
// Assumes the bound checker and config_map.vh on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "config_map.vh"
module test_config_index_port_access;
  logic clk_sys = 0, sys_rst = 1, bus_reset = 0, main_power_good = 1;
  logic port_address_strap = 0, clock_rate_strap = 1, pin_function_strap = 0, standby_strap = 1;
  logic io_wr = 0, io_rd = 0, io_rvalid, bank_wr, bank_rd, extended_mode, port_address_sel;
  logic pin_function_sel, standby_strap_sel;
  logic [15:0] io_addr = 0, base;
  logic [7:0] io_wdata = 0, io_rdata, bank_index, bank_wdata, bank_rdata, function_bank_select;
  logic [7:0] got, r, v;
  logic [2:0] bank_target;
  logic [5:0] main_clock_mhz;
  logic [7:0] banks [9] = '{8'h02, 8'h03, 8'h07, 8'h08, 8'h0f, 8'h10, 8'h11, 8'h14, 8'h05};
  int n_mismatch = 0, comparisons = 0, cyc_n = 0, i;
  config_index_port_access u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_reset(bus_reset),
    .main_power_good(main_power_good), .port_address_strap(port_address_strap),
    .clock_rate_strap(clock_rate_strap), .pin_function_strap(pin_function_strap),
    .standby_strap(standby_strap), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .bank_wr(bank_wr),
    .bank_rd(bank_rd), .bank_target(bank_target), .bank_index(bank_index),
    .bank_wdata(bank_wdata), .bank_rdata(bank_rdata), .extended_mode(extended_mode),
    .function_bank_select(function_bank_select), .port_address_sel(port_address_sel),
    .main_clock_mhz(main_clock_mhz), .pin_function_sel(pin_function_sel),
    .standby_strap_sel(standby_strap_sel));
  bank_model u_bank (.clk_sys(clk_sys), .bank_wr(bank_wr), .bank_wdata(bank_wdata),
    .bank_rdata(bank_rdata));
  initial forever #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", name, e, g);
      n_mismatch++;
    end
  endtask
  // One host cycle per call, driven at the falling edge
  task automatic cyc(input logic w, input logic rv, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    io_wr = w;
    io_rd = rv;
    io_addr = a;
    io_wdata = d;
  endtask
  task automatic idle();
    cyc(0, 0, 16'h0000, 8'h00);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cyc(1, 0, a, d);
  endtask
  task automatic rd(input logic [15:0] a);
    cyc(0, 1, a, 8'h00);
    idle();
    got = io_rdata;
  endtask
  task automatic cfg(input logic [7:0] x, input logic [7:0] d);
    wr(base, x);
    wr(base + 16'h0001, d);
  endtask
  task automatic cfg_rd(input logic [7:0] x);
    wr(base, x);
    rd(base + 16'h0001);
  endtask
  task automatic unlock();
    wr(base, `KEY_UNLOCK);
    wr(base, `KEY_UNLOCK);
    idle();
  endtask
  function automatic logic [2:0] tgt(input logic [7:0] b);
    case (b)
      8'h02: tgt = 3'd1;
      8'h03: tgt = 3'd2;
      8'h10: tgt = 3'd3;
      8'h11: tgt = 3'd4;
      8'h07, 8'h0f: tgt = 3'd5;
      8'h08: tgt = 3'd6;
      8'h14: tgt = 3'd7;
      default: tgt = 3'd0;
    endcase
  endfunction
  initial begin
    void'($urandom(32'h22b8));
    port_address_strap = 1'($urandom);
    repeat (20) @(negedge clk_sys);
    sys_rst = 0;
    base = port_address_strap ? `PORT_BASE_HIGH : `PORT_BASE_LOW;
    repeat (2) idle();
    chk("port sel", port_address_strap, port_address_sel);
    chk("clock mhz", 8'd48, main_clock_mhz);
    wr(base, `KEY_UNLOCK);
    wr(base, 8'h55);
    wr(base, `KEY_UNLOCK);
    idle();
    chk("half unlock", 0, extended_mode);
    wr(base, 8'h00);
    rd(base + 16'h0001);
    chk("locked read", `READ_IDLE, got);
    unlock();
    chk("unlock", 1, extended_mode);
    $display("test unlock done");
    for (i = 0; i < 9; i++) begin
      r = 8'h30 + 8'($urandom_range(207, 0));
      if (r == `KEY_LOCK) r = 8'hab;
      v = 8'($urandom);
      cfg(`IDX_BANK_SELECT, banks[i]);
      cfg(r, v);
      idle();
      if (tgt(banks[i]) != 3'd0) begin
        chk("target", tgt(banks[i]), bank_target);
        chk("bank index", r, bank_index);
        chk("bank data", v, bank_wdata);
      end
      cfg_rd(r);
      chk("bank read", (tgt(banks[i]) != 3'd0) ? v : `READ_IDLE, got);
      chk("bank rd", tgt(banks[i]) != 3'd0, bank_rd);
      chk("bank sel", banks[i], function_bank_select);
    end
    $display("test banks done");
    for (i = 0; i < 6; i++) begin
      r = 8'($urandom_range(47, 8));
      if (r == 8'h26 || r == 8'h2a || r == 8'h2b) r = 8'h2f;
      v = 8'($urandom);
      cfg(r, v);
      cfg_rd(r);
      chk("global", v, got);
      rd(base);
      chk("index", r, got);
    end
    cfg_rd(`IDX_STRAP_READBACK);
    chk("readback", port_address_strap, got[6]);
    $display("test globals done");
    wr(base, `KEY_LOCK);
    idle();
    chk("lock", 0, extended_mode);
    wr(base + 16'h0001, ~v);
    unlock();
    cfg_rd(r);
    chk("locked write", v, got);
    chk("bank kept", 8'h05, function_bank_select);
    main_power_good = 0;
    clock_rate_strap = 0;
    pin_function_strap = 1;
    repeat (4) idle();
    chk("clock low", 8'd24, main_clock_mhz);
    chk("pin sel", 1, pin_function_sel);
    main_power_good = 1;
    idle();
    clock_rate_strap = 1;
    cfg_rd(`IDX_MAIN_STRAPS);
    chk("main straps", 8'h02, got);
    cfg(`IDX_MAIN_STRAPS, 8'h01);
    repeat (2) idle();
    chk("clock set", 8'd48, main_clock_mhz);
    chk("pin set", 0, pin_function_sel);
    cfg(`IDX_STANDBY_STRAPS, 8'h00);
    $display("test straps done");
    port_address_strap = ~port_address_strap;
    bus_reset = 1;
    idle();
    bus_reset = 0;
    base = port_address_strap ? `PORT_BASE_HIGH : `PORT_BASE_LOW;
    repeat (2) idle();
    chk("port moved", port_address_strap, port_address_sel);
    chk("mode cleared", 0, extended_mode);
    chk("bank cleared", `RESET_BANK, function_bank_select);
    chk("standby kept", 0, standby_strap_sel);
    unlock();
    chk("new pair", 1, extended_mode);
    cfg_rd(`IDX_STRAP_READBACK);
    chk("new readback", port_address_strap, got[6]);
    sys_rst = 1;
    idle();
    sys_rst = 0;
    repeat (2) idle();
    chk("standby back", 1, standby_strap_sel);
    $display("test resets done");
    close_out();
  end
endmodule
`default_nettype wire
